//--- logic/wdr_pkg.sv
// Purpose: constants for the watchdog and reset-flag block
// Assumes: 250 MHz system clock, byte-wide register port
// Notes: register offsets are word indices on the plain register port
//
// Function
// - watchdog counts divided low-speed source clock
// - timeout_select picks 2^8..2^18 source cycles
// - normal-mode overflow gives full reset, sets expiry_flag
// - low-power overflow sets expiry_flag, clears pc/sp only
// - always-on option: both legal keys enable
// - register option: 10101 disables, 01010 enables
// - illegal key resets after 2-3 source cycles
// - power-on loads key 01010, select 011
// - counter cleared by key reset, clear, stop
// - straps choose always-on and clear type
// - idle_sysclk_on keeps system clock in idle
// - system_control bits 6..3 read zero
// - lowvolt_reset_flag set by hardware, software zero-clears
// - lvsel_reset_flag set on undefined selection value
// - wdog_key_reset_flag set by illegal key reset
// - power-on reset clears program counter
// - power-on reset presets port registers to ones
// - power-on delay of 50 ms before execution
// - external clear shares pin with port_a_bit7
// - pin low inhibits; start_delay after release
// - external circuit holds pin low until supply settles
// - powerdown_flag set by stop, cleared by clear
// - stop clears counter and expiry_flag

package wdr_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned LOW_RC_HZ = 32_000;
  localparam int unsigned SRC_DIV_CYC = CLK_HZ / LOW_RC_HZ;
  localparam int unsigned START_DELAY_MS = 50;
  localparam int unsigned START_DELAY_CYC = (CLK_HZ / 1000) * START_DELAY_MS;

  localparam logic [3:0] OFS_WATCHDOG_CONTROL = 4'h0;
  localparam logic [3:0] OFS_SYSTEM_CONTROL = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;

  localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h53;
  localparam int unsigned KEY_LSB = 3;
  localparam int unsigned SEL_LSB = 0;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE = 5'h0a;

  localparam int unsigned SYSCTL_IDLE_SYSCLK = 7;
  localparam int unsigned SYSCTL_LOWVOLT = 2;
  localparam int unsigned SYSCTL_LVSEL = 1;
  localparam int unsigned SYSCTL_WDOG_KEY = 0;
  localparam int unsigned STAT_POWERDOWN = 0;
  localparam int unsigned STAT_EXPIRY = 1;

  localparam int unsigned WDT_W = 19;
  localparam int unsigned KEY_FIRE_TICKS = 3;

  typedef enum logic [1:0] {
    WDR_HOLD = 2'b00,
    WDR_DELAY = 2'b01,
    WDR_RUN = 2'b10
  } wdr_seq_t;

endpackage : wdr_pkg

//--- logic/wdr_top.sv
// Purpose: watchdog timer, reset sequencer and reset-source flags
// Assumes: all inputs synchronous to i_sys_clk; i_resetn is power-on
// Notes: low-speed source derived from the system clock by a divider
//
// Design decisions made here: the strobed register port and the register addresses.

`timescale 1ns/1ps
`default_nettype none

module wdr_top #(
  parameter int unsigned SRC_DIV = wdr_pkg::SRC_DIV_CYC,
  parameter int unsigned START_CYC = wdr_pkg::START_DELAY_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cfg_always_on,
  input wire logic i_cfg_pin_reset,
  input wire logic i_clear_watchdog_instr,
  input wire logic i_stop_instruction,
  input wire logic i_low_power,
  input wire logic i_lowvolt_event,
  input wire logic i_lvsel_undefined,
  input wire logic i_port_a_bit7,
  output logic [7:0] o_rdata,
  output logic o_cpu_reset,
  output logic o_pc_sp_clear,
  output logic o_port_a_bit7,
  output logic o_idle_sysclk_on,
  output logic o_wdt_enabled
);
  import wdr_pkg::*;

  // prescaler and delay counters are 24 bits wide; refuse values they cannot hold
  if (SRC_DIV < 2 || SRC_DIV > 32'h00ff_ffff) begin : g_bad_div
    $error("SRC_DIV out of range");
  end
  if (START_CYC < 1 || START_CYC > 32'h00ff_ffff) begin : g_bad_start
    $error("START_CYC out of range");
  end

  localparam logic [23:0] SRC_LAST = 24'(SRC_DIV - 1);
  localparam logic [23:0] START_LAST = 24'(START_CYC - 1);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctl_word;
    logic idle_sysclk_on;
    logic lowvolt_flag;
    logic lvsel_flag;
    logic key_flag;
    logic expiry_flag;
    logic powerdown_flag;
    logic [WDT_W-1:0] wdt_cnt;
    logic [23:0] pre_cnt;
    logic [1:0] key_ticks;
    wdr_seq_t seq;
    logic [23:0] dly_cnt;
    logic [7:0] rdata;
    logic cpu_reset;
    logic pc_sp_clear;
    logic port_bit;
    logic wdt_en;
  } wdr_state_t;

  wdr_state_t st;
  wdr_state_t next_st;

  // ==========================================================
  // timeout selection
  function automatic logic [WDT_W-1:0] wdr_limit(input logic [2:0] sel);
    logic [4:0] shift;
    shift = 5'h08;
    unique case (sel)
      3'h0: shift = 5'h08;
      3'h1: shift = 5'h0a;
      3'h2: shift = 5'h0c;
      3'h3: shift = 5'h0e;
      3'h4: shift = 5'h0f;
      3'h5: shift = 5'h10;
      3'h6: shift = 5'h11;
      3'h7: shift = 5'h12;
    endcase
    wdr_limit = WDT_W'((20'h1 << shift) - 20'h1);
  endfunction : wdr_limit

  // ==========================================================
  // combinational next state
  logic [4:0] key;
  logic [2:0] sel;
  logic key_legal;
  logic wdt_enable;
  logic src_tick;
  logic wdt_ovf;
  logic key_fire;
  logic pin_low;
  logic full_reset;
  logic running;

  always_comb begin
    next_st = st;
    key = st.ctl_word[KEY_LSB +: 5];
    sel = st.ctl_word[SEL_LSB +: 3];
    key_legal = (key == KEY_ENABLE) || (key == KEY_DISABLE);
    running = (st.seq == WDR_RUN);

    // legal keys: always-on strap ignores the disable code
    wdt_enable = i_cfg_always_on ? key_legal : (key == KEY_ENABLE);

    // low-speed source tick from the system clock
    src_tick = (st.pre_cnt == SRC_LAST);
    next_st.pre_cnt = src_tick ? 24'h0 : st.pre_cnt + 24'h1;

    wdt_ovf = running && wdt_enable && src_tick && (st.wdt_cnt == wdr_limit(sel));

    // illegal key fires on the third source tick: 2 to 3 full source cycles
    key_fire = 1'b0;
    if (!running || key_legal) begin
      next_st.key_ticks = 2'h0;
    end else if (src_tick) begin
      if (st.key_ticks == 2'(KEY_FIRE_TICKS - 1)) begin
        key_fire = 1'b1;
        next_st.key_ticks = 2'h0;
      end else begin
        next_st.key_ticks = st.key_ticks + 2'h1;
      end
    end

    pin_low = i_cfg_pin_reset && !i_port_a_bit7;
    full_reset = (wdt_ovf && !i_low_power) || key_fire
      || i_lowvolt_event || i_lvsel_undefined || pin_low;

    // ----- watchdog counter
    if (!running || !wdt_enable) begin
      next_st.wdt_cnt = '0;
    end else if (i_clear_watchdog_instr || i_stop_instruction || wdt_ovf) begin
      next_st.wdt_cnt = '0;
    end else if (src_tick) begin
      next_st.wdt_cnt = st.wdt_cnt + WDT_W'(1);
    end

    // ----- register writes; software can only zero the reset flags
    if (i_wr && i_addr == OFS_WATCHDOG_CONTROL) begin
      next_st.ctl_word = i_wdata;
    end
    if (i_wr && i_addr == OFS_SYSTEM_CONTROL) begin
      next_st.idle_sysclk_on = i_wdata[SYSCTL_IDLE_SYSCLK];
      next_st.lowvolt_flag = st.lowvolt_flag & i_wdata[SYSCTL_LOWVOLT];
      next_st.lvsel_flag = st.lvsel_flag & i_wdata[SYSCTL_LVSEL];
      next_st.key_flag = st.key_flag & i_wdata[SYSCTL_WDOG_KEY];
    end

    // ----- hardware sets win over a same-cycle software clear
    if (i_lowvolt_event) begin
      next_st.lowvolt_flag = 1'b1;
    end
    if (i_lvsel_undefined) begin
      next_st.lvsel_flag = 1'b1;
    end
    if (key_fire) begin
      next_st.key_flag = 1'b1;
    end

    // ----- status flags
    if (running && i_stop_instruction) begin
      next_st.powerdown_flag = 1'b1;
      next_st.expiry_flag = 1'b0;
    end else if (running && i_clear_watchdog_instr) begin
      next_st.powerdown_flag = 1'b0;
    end
    if (wdt_ovf) begin
      next_st.expiry_flag = 1'b1;
    end

    // pc/sp clear only, rest of the state is kept
    next_st.pc_sp_clear = wdt_ovf && i_low_power;

    // ----- reset sequencer
    unique case (st.seq)
      WDR_HOLD: begin
        next_st.dly_cnt = 24'h0;
        if (!pin_low) begin
          next_st.seq = WDR_DELAY;
        end
      end
      WDR_DELAY: begin
        if (pin_low) begin
          next_st.seq = WDR_HOLD;
        end else if (st.dly_cnt == START_LAST) begin
          next_st.seq = WDR_RUN;
        end else begin
          next_st.dly_cnt = st.dly_cnt + 24'h1;
        end
      end
      WDR_RUN: begin
        if (full_reset) begin
          next_st.seq = WDR_HOLD;
        end
      end
      default: begin
        next_st.seq = WDR_HOLD;
      end
    endcase

    // reload the control word so an illegal key cannot loop the reset
    if (running && full_reset) begin
      next_st.ctl_word = WATCHDOG_CONTROL_RST;
      next_st.wdt_cnt = '0;
    end

    // execution held while not running; pc at zero, ports as inputs
    next_st.cpu_reset = (next_st.seq != WDR_RUN);
    // pin reads as port data only when not a clear input
    next_st.port_bit = i_cfg_pin_reset ? 1'b1 : i_port_a_bit7;
    next_st.wdt_en = wdt_enable;

    // ----- read data, valid the cycle after the strobe
    next_st.rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        OFS_WATCHDOG_CONTROL: next_st.rdata = st.ctl_word;
        OFS_SYSTEM_CONTROL: begin
          next_st.rdata[SYSCTL_IDLE_SYSCLK] = st.idle_sysclk_on;
          next_st.rdata[SYSCTL_LOWVOLT] = st.lowvolt_flag;
          next_st.rdata[SYSCTL_LVSEL] = st.lvsel_flag;
          next_st.rdata[SYSCTL_WDOG_KEY] = st.key_flag;
        end
        OFS_STATUS: begin
          next_st.rdata[STAT_POWERDOWN] = st.powerdown_flag;
          next_st.rdata[STAT_EXPIRY] = st.expiry_flag;
        end
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registers; power-on values
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st.ctl_word <= WATCHDOG_CONTROL_RST;
      st.idle_sysclk_on <= 1'b0;
      st.lowvolt_flag <= 1'b0;
      st.lvsel_flag <= 1'b0;
      st.key_flag <= 1'b0;
      st.expiry_flag <= 1'b0;
      st.powerdown_flag <= 1'b0;
      st.wdt_cnt <= '0;
      st.pre_cnt <= 24'h0;
      st.key_ticks <= 2'h0;
      st.seq <= WDR_DELAY;
      st.dly_cnt <= 24'h0;
      st.rdata <= 8'h00;
      st.cpu_reset <= 1'b1;
      st.pc_sp_clear <= 1'b0;
      st.port_bit <= 1'b1;
      st.wdt_en <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_cpu_reset = st.cpu_reset;
  assign o_pc_sp_clear = st.pc_sp_clear;
  assign o_port_a_bit7 = st.port_bit;
  assign o_idle_sysclk_on = st.idle_sysclk_on;
  assign o_wdt_enabled = st.wdt_en;

endmodule : wdr_top

`default_nettype wire

//--- sim/tb_wdr_top.sv
// Purpose: self-checking bench for wdr_top
// Assumes: divider 4 and start delay 20 keep the run short
// Notes: register table first, then hand-written event tests
`timescale 1ns/1ps
`default_nettype none
module tb_wdr_top;
  import wdr_pkg::*;
  localparam int DIV = 4;
  localparam int SD = 20;
  typedef struct packed {logic w; logic [3:0] ad; logic [7:0] v; logic [7:0] e;} wdr_row_t;
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_low_power = 1'b0;
  logic i_cfg_always_on = 1'b0, i_cfg_pin_reset = 1'b0, i_port_a_bit7 = 1'b1;
  logic i_clear_watchdog_instr = 1'b0, i_stop_instruction = 1'b0;
  logic i_lowvolt_event = 1'b0, i_lvsel_undefined = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic o_cpu_reset, o_pc_sp_clear, o_port_a_bit7, o_idle_sysclk_on, o_wdt_enabled;
  int err_total = 0;
  int n_tests = 0;
  int n;
  wdr_row_t rows [6] = '{'{1'b0, 4'h0, 8'h00, 8'h53}, '{1'b1, 4'h0, 8'h52, 8'h52},
    '{1'b1, 4'h1, 8'hff, 8'h80}, '{1'b0, 4'h2, 8'h00, 8'h00},
    '{1'b1, 4'h2, 8'hff, 8'h00}, '{1'b1, 4'h9, 8'hff, 8'h00}};
  always #2 i_sys_clk = ~i_sys_clk;
  wdr_top #(.SRC_DIV(DIV), .START_CYC(SD)) dut_u (.i_sys_clk, .i_resetn, .i_addr, .i_wdata,
    .i_wr, .i_rd, .i_cfg_always_on, .i_cfg_pin_reset, .i_clear_watchdog_instr,
    .i_stop_instruction, .i_low_power, .i_lowvolt_event, .i_lvsel_undefined, .i_port_a_bit7,
    .o_rdata, .o_cpu_reset, .o_pc_sp_clear, .o_port_a_bit7, .o_idle_sysclk_on, .o_wdt_enabled);
  // ==========================================
  // tasks
  task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic wreg(logic [3:0] ad, logic [7:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wreg
  task automatic rreg(logic [3:0] ad, logic [7:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", o_rdata, e);
  endtask : rreg
  task automatic pulse(int k);
    @(posedge i_sys_clk);
    case (k)
      0: i_clear_watchdog_instr <= 1'b1;
      1: i_stop_instruction <= 1'b1;
      2: i_lowvolt_event <= 1'b1;
      default: i_lvsel_undefined <= 1'b1;
    endcase
    @(posedge i_sys_clk);
    {i_clear_watchdog_instr, i_stop_instruction, i_lowvolt_event, i_lvsel_undefined} <= 4'h0;
  endtask : pulse
  // n ends as the cycle count of the wait
  task automatic wait_on(int k, logic lvl, int lim);
    n = 0;
    while ((k == 1 ? o_pc_sp_clear : o_cpu_reset) !== lvl && n < lim) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
  endtask : wait_on
  // ==========================================
  // sequence
  initial begin
    repeat (2) @(posedge i_sys_clk);
    #1 chk("por", {o_cpu_reset, o_port_a_bit7, o_idle_sysclk_on, o_wdt_enabled, o_rdata[3:0]},
      8'hc0);
    @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    wait_on(0, 1'b0, 100);
    chk("start", 8'(n >= SD), 8'h01);
    foreach (rows[i]) begin
      if (rows[i].w) wreg(rows[i].ad, rows[i].v);
      rreg(rows[i].ad, rows[i].e);
    end
    chk("idle", {7'h0, o_idle_sysclk_on}, 8'h01);
    $display("register table done");
    for (int c = 0; c < 3; c++) begin
      wreg(OFS_WATCHDOG_CONTROL, {KEY_ENABLE, 3'(c)});
      pulse(0);
      wait_on(0, 1'b1, 20000);
      chk("period", 8'(n + 12 >= (DIV << (8 + 2 * c)) && n <= (DIV << (8 + 2 * c)) + 12),
        8'h01);
      wait_on(0, 1'b0, 200);
      rreg(OFS_STATUS, 8'h02);
      rreg(OFS_WATCHDOG_CONTROL, 8'h53);
    end
    $display("timeouts done");
    wreg(OFS_WATCHDOG_CONTROL, 8'h00);
    wait_on(0, 1'b1, 14);
    chk("keyrst", {7'h0, o_cpu_reset}, 8'h01);
    chk("keydly", 8'(n >= 2 * DIV && n <= 3 * DIV), 8'h01);
    wait_on(0, 1'b0, 200);
    pulse(2);
    wait_on(0, 1'b1, 10);
    wait_on(0, 1'b0, 200);
    pulse(3);
    wait_on(0, 1'b1, 10);
    wait_on(0, 1'b0, 200);
    rreg(OFS_SYSTEM_CONTROL, 8'h87);
    wreg(OFS_SYSTEM_CONTROL, 8'h80);
    rreg(OFS_SYSTEM_CONTROL, 8'h80);
    pulse(1);
    rreg(OFS_STATUS, 8'h01);
    pulse(0);
    rreg(OFS_STATUS, 8'h00);
    $display("flags done");
    wreg(OFS_WATCHDOG_CONTROL, {KEY_DISABLE, 3'h0});
    repeat (1200) @(posedge i_sys_clk);
    rreg(OFS_STATUS, 8'h00);
    chk("off", {7'h0, o_wdt_enabled}, 8'h00);
    @(posedge i_sys_clk);
    i_cfg_always_on <= 1'b1;
    wreg(OFS_WATCHDOG_CONTROL, {KEY_DISABLE, 3'h0});
    repeat (2) @(posedge i_sys_clk);
    #1 chk("aon", {7'h0, o_wdt_enabled}, 8'h01);
    @(posedge i_sys_clk);
    i_low_power <= 1'b1;
    pulse(0);
    wait_on(1, 1'b1, 1100);
    chk("lowpwr", {6'h0, o_cpu_reset, o_pc_sp_clear}, 8'h01);
    @(posedge i_sys_clk);
    i_low_power <= 1'b0;
    rreg(OFS_STATUS, 8'h02);
    $display("modes done");
    @(posedge i_sys_clk);
    i_cfg_pin_reset <= 1'b1;
    i_port_a_bit7 <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    #1 chk("pin", {6'h0, o_cpu_reset, o_port_a_bit7}, 8'h03);
    @(posedge i_sys_clk);
    i_port_a_bit7 <= 1'b1;
    wait_on(0, 1'b0, 200);
    chk("pindly", 8'(n >= SD), 8'h01);
    @(posedge i_sys_clk);
    i_cfg_pin_reset <= 1'b0;
    i_port_a_bit7 <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1 chk("port", {7'h0, o_port_a_bit7}, 8'h00);
    $display("pin done");
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1 chk("rerst", {o_cpu_reset, o_port_a_bit7, o_idle_sysclk_on, o_wdt_enabled, o_rdata[3:0]},
      8'hc0);
    @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    wait_on(0, 1'b0, 100);
    chk("restart", 8'(n >= SD), 8'h01);
    rreg(OFS_WATCHDOG_CONTROL, 8'h53);
    $display("reset done");
    stop_test();
  end
  // run needs about 25k cycles
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule : tb_wdr_top
`default_nettype wire

//--- sim/wdr_top_asserts.sv
// Purpose: port-level assertions for wdr_top
// Assumes: bench runs the short divider (key reset window below)
// Notes: bind statement at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module wdr_asserts import wdr_pkg::*; #(
  parameter int unsigned SRC_DIV = 4,
  parameter int unsigned START_CYC = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cfg_always_on,
  input wire logic i_cfg_pin_reset,
  input wire logic i_port_a_bit7,
  input wire logic [7:0] o_rdata,
  input wire logic o_cpu_reset,
  input wire logic o_pc_sp_clear,
  input wire logic o_port_a_bit7,
  input wire logic o_idle_sysclk_on,
  input wire logic o_wdt_enabled
);
  // ==========================================
  // helpers
  logic [31:0] hold_cnt;
  logic key_wr;
  logic [4:0] key;
  assign key_wr = i_wr && i_addr == OFS_WATCHDOG_CONTROL && !o_cpu_reset;
  assign key = i_wdata[7:3];
  // counts the whole held span, so a short start delay shows at the fall
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) hold_cnt <= 32'h0;
    else if (o_cpu_reset) hold_cnt <= hold_cnt + 32'h1;
    else hold_cnt <= 32'h0;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================
  // properties
  AST_SYSCTL_GAP: assert property (
    $past(i_rd) && $past(i_addr) == OFS_SYSTEM_CONTROL |-> o_rdata[6:3] == 4'h0)
    else $error("system_control gap bits not zero");
  AST_HOLD_LEN: assert property (
    $fell(o_cpu_reset) |-> hold_cnt >= START_CYC) else $error("start delay too short");
  AST_PIN_HOLD: assert property (
    i_cfg_pin_reset && !i_port_a_bit7 |-> ##2 o_cpu_reset) else $error("pin low not held");
  AST_PIN_SHARE: assert property (
    i_cfg_pin_reset [*3] |-> o_port_a_bit7) else $error("clear pin drives port data");
  AST_KEY_OFF: assert property (
    key_wr && key == KEY_DISABLE && !i_cfg_always_on |-> ##2 !o_wdt_enabled)
    else $error("disable key ignored");
  AST_KEY_ON: assert property (
    key_wr && (key == KEY_ENABLE || (i_cfg_always_on && key == KEY_DISABLE))
    |-> ##2 o_wdt_enabled) else $error("legal key did not enable");
  AST_BAD_KEY: assert property (
    key_wr && key != KEY_ENABLE && key != KEY_DISABLE |-> ##[1:14] o_cpu_reset)
    else $error("illegal key did not reset");
  AST_KEY_DLY: assert property (
    key_wr && key != KEY_ENABLE && key != KEY_DISABLE |-> ##1 !o_cpu_reset [*8])
    else $error("illegal key reset too early");
  AST_PCSP: assert property (
    o_pc_sp_clear |-> !o_cpu_reset ##1 !o_pc_sp_clear) else $error("pc clear not a lone pulse");
  AST_IDLE_CLK: assert property (
    i_wr && i_addr == OFS_SYSTEM_CONTROL |-> ##2 o_idle_sysclk_on == $past(i_wdata[7], 2))
    else $error("idle clock bit not taken");
endmodule : wdr_asserts
bind wdr_top wdr_asserts #(.SRC_DIV(SRC_DIV), .START_CYC(START_CYC)) u_asserts (
  .i_sys_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_cfg_always_on,
  .i_cfg_pin_reset, .i_port_a_bit7, .o_rdata, .o_cpu_reset, .o_pc_sp_clear,
  .o_port_a_bit7, .o_idle_sysclk_on, .o_wdt_enabled);
`default_nettype wire
